// *** design/sxc_pkg_sync.sv ***
`timescale 1ns/1ps
`default_nettype none

package sxc_pkg;
  // character field widths
  localparam int CHAR_W  = 8;
  localparam int CT_W    = 2;
  localparam int RAW_W   = 10;
  // phase-align buffer geometry
  localparam int PTR_W   = 4;
  localparam int IDX_W   = 3;
  localparam logic [PTR_W-1:0] PTR_ZERO   = 4'h0;
  localparam logic [PTR_W-1:0] PTR_ONE    = 4'h1;
  localparam logic [PTR_W-1:0] FILL_FAULT = 4'h8;  // wrapped or lapped
  localparam logic [PTR_W-1:0] CENTER     = 4'h4;  // read lag after recenter
  // phase reset must be seen low on this many edges
  localparam logic [1:0] PRST_EDGES = 2'h2;
  localparam logic [1:0] CNT_ZERO   = 2'h0;
  localparam logic [1:0] CNT_ONE    = 2'h1;
  // three-level static selects
  localparam logic [1:0] LVL_LOW  = 2'h0;
  localparam logic [1:0] LVL_MID  = 2'h1;
  localparam logic [1:0] LVL_HIGH = 2'h2;
  // control code meanings with encoder on
  localparam logic [1:0] CT_DATA    = 2'h0;
  localparam logic [1:0] CT_SPECIAL = 2'h1;
  localparam logic [1:0] CT_FILL    = 2'h2;
  localparam logic [1:0] CT_WSS     = 2'h3;
  // code-violation replacement character
  localparam logic [CHAR_W-1:0] CVIOL_CODE = 8'he0;
  localparam logic [CT_W-1:0]   CT_NONE    = 2'h0;

  // one captured input word
  typedef struct packed {
    logic [CHAR_W-1:0] chr;
    logic [CT_W-1:0]   ct;
    logic              par;
    logic              sc;
  } sxc_word_t;

  // how the encoder must treat a character
  typedef enum logic [2:0] {
    K_DATA, K_SPECIAL, K_FILL, K_WSS, K_RAW, K_VIOL
  } sxc_kind_t;

  // character handed to the encoder or shifter
  typedef struct packed {
    sxc_kind_t         kind;
    logic [RAW_W-1:0]  bits;
  } sxc_char_t;

  // binary to gray
  function automatic logic [PTR_W-1:0] bin2gray(input logic [PTR_W-1:0] b);
    bin2gray = b ^ (b >> 1);
  endfunction

  // gray to binary
  function automatic logic [PTR_W-1:0] gray2bin(input logic [PTR_W-1:0] g);
    logic [PTR_W-1:0] b;
    b = g;
    for (int i = PTR_W - 2; i >= 0; i--) begin
      b[i] = b[i+1] ^ g[i];
    end
    gray2bin = b;
  endfunction

  // odd parity fails when enabled
  function automatic logic par_bad(input sxc_word_t w, input logic [1:0] pctl);
    logic p;
    p = ^w.chr ^ w.par;
    if (pctl == LVL_HIGH) begin
      p = p ^ (^w.ct);
    end
    par_bad = (pctl != LVL_LOW) && !p;
  endfunction
endpackage

// three-stage synchroniser; settled when last two stages agree
module sxc_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,      // destination clock
  input  wire logic [W-1:0] d,        // foreign input
  output logic      [W-1:0] q,        // synchronised value
  output logic              settled   // stages two and three agree
);
  logic [W-1:0] s1_r;  // metastability catcher
  logic [W-1:0] s2_r;  // second stage
  logic [W-1:0] s3_r;  // third stage

  // shift chain
  always_ff @(posedge clk) begin
    s1_r <= d;
    s2_r <= s1_r;
    s3_r <= s2_r;
  end

  assign q       = s3_r;
  assign settled = (s2_r == s3_r);
endmodule

`default_nettype wire

// *** design/sxc_tx_input_port.sv ***
// Overview of operation
// RQ1: capture control code on selected clock
// RQ2: encoder uses code to pick character type
// RQ3: bypassed encoder treats code as data
// RQ4: capture eight character bits each edge
// RQ5: upper mode bit set enables encoder
// RQ6: bypass forms ten-bit raw character
// RQ7: check odd parity when parity enabled
// RQ8: special select marks specials or sync
// RQ9: special select sampled on host clock
// RQ10: half rate samples both reference edges
// RQ11: phase reset low recenters buffer
// RQ12: phase reset high keeps phase fixed
// RQ13: half rate reset only clears faults
// RQ14: recentering may repeat or drop characters
// RQ15: host holds reset low two edges
// RQ16: full rate reference ignores phase reset
// RQ17: host asserts reset during initialization
// RQ18: host resets after jtag, clock, lock
// RQ19: reference or host clock feeds register
// RQ20: half rate never with host clock
// RQ21: parity error pulses, substitutes violation
// RQ22: buffer fault holds error until cleared
// RQ23: one edge's inputs travel together
`timescale 1ns/1ps
`default_nettype none

module sxc_tx_input_port
  import sxc_pkg::*;
(
  input  wire logic        CLK,                     // reference clock, 50 MHz
  input  wire logic        RST_B,                   // synchronous reset, active low
  input  wire logic        HOST_TRANSMIT_CLOCK,     // host transmit clock
  input  wire logic [7:0]  TX_CHAR,                 // transmit character
  input  wire logic [1:0]  TRANSMIT_CHAR_TYPE_CODE, // control code
  input  wire logic        TRANSMIT_ODD_PARITY_IN,  // odd parity bit
  input  wire logic        SPECIAL_CHAR_SELECT,     // special select
  input  wire logic        PHASE_ALIGN_RESET_N,     // phase reset, active low, async
  input  wire logic [1:0]  INPUT_CLOCK_SELECT,      // 0 ref, 1 mid, 2 high
  input  wire logic        HALF_RATE_SELECT,        // both reference edges
  input  wire logic [1:0]  TRANSMIT_CODING_MODE,    // bit 1 enables encoder
  input  wire logic [1:0]  PARITY_CONTROL,          // 0 off, 1 char, 2 char+code
  output logic             TRANSMIT_PARITY_ERROR_OUT, // parity or buffer error
  output var sxc_char_t    CHAR_OUT,                // first character of cycle
  output logic             CHAR_OUT_VALID,          // first character present
  output var sxc_char_t    CHAR_OUT2,               // falling-edge character
  output logic             CHAR_OUT2_VALID,         // second character present
  output logic             PHASE_ALIGN_ACTIVE       // recentering in progress
);

  sxc_word_t        in_word;        // live input word
  sxc_word_t        rise_r;         // rising-edge capture
  sxc_word_t        fall_r;         // falling-edge capture
  sxc_word_t        mem [0:(1<<IDX_W)-1]; // phase-align buffer
  logic [PTR_W-1:0] wr_bin_r;       // host-side write pointer
  logic [PTR_W-1:0] wr_gray_r;      // gray copy for crossing
  logic [PTR_W-1:0] wr_gray_s;      // synchronised gray pointer
  logic [PTR_W-1:0] wr_bin_s;       // synchronised binary pointer
  logic [PTR_W-1:0] rd_bin_r;       // read pointer
  logic [PTR_W-1:0] fill;           // words held
  logic             host_rst_b;     // reset seen in host domain
  logic             prst_q;         // synchronised phase reset
  logic             prst_settled;   // synchroniser agrees
  logic             prst_low_r;     // phase reset seen low
  logic [1:0]       prst_cnt_r;     // consecutive low edges
  logic             prst_active;    // low long enough
  logic             ref_clk_sel;    // input register on reference clock
  logic             buf_bypass;     // full rate reference capture
  logic             recenter;       // buffer adjustment this cycle
  logic             buf_fault;      // underflow or overflow
  logic             enc_on;         // encoder enabled
  sxc_word_t        lane_a;         // first word this cycle
  logic             lane_a_ok;      // first word present
  logic             lane_b_ok;      // second word present
  logic             perr_a;         // parity fault first lane
  logic             perr_b;         // parity fault second lane
  logic             perr_r;         // registered parity pulse
  logic             err_hold_r;     // sticky buffer fault
  logic             wss_sent;       // sync sequence leaving
  sxc_char_t        char_a;         // encoded first character
  sxc_char_t        char_b;         // encoded second character

  // classify one word for the encoder or shifter
  function automatic sxc_char_t encode(input sxc_word_t w, input logic enc,
                                       input logic [1:0] pctl);
    sxc_char_t c;
    c.bits = {w.ct, w.chr};
    c.kind = K_DATA;
    if (par_bad(w, pctl)) begin
      c.kind = K_VIOL;
      c.bits = {CT_NONE, CVIOL_CODE};
    end else if (!enc) begin
      c.kind = K_RAW;
    end else begin
      case (w.ct)
        CT_DATA:    c.kind = w.sc ? K_SPECIAL : K_DATA;
        CT_SPECIAL: c.kind = K_SPECIAL;
        CT_FILL:    c.kind = K_FILL;
        CT_WSS:     c.kind = w.sc ? K_WSS : K_SPECIAL;
        default:    c.kind = K_DATA;
      endcase
    end
    encode = c;
  endfunction

  // all captured pins form one word
  // RQ23: word kept together
  assign in_word = '{chr: TX_CHAR, ct: TRANSMIT_CHAR_TYPE_CODE,
                     par: TRANSMIT_ODD_PARITY_IN, sc: SPECIAL_CHAR_SELECT};

  // static configuration decode
  assign ref_clk_sel = (INPUT_CLOCK_SELECT == LVL_LOW);
  assign buf_bypass  = ref_clk_sel && !HALF_RATE_SELECT;
  // RQ5: upper mode bit
  assign enc_on      = TRANSMIT_CODING_MODE[1];

  // reference rising-edge capture
  // RQ1: rising edge capture
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rise_r <= '0;
    end else begin
      rise_r <= in_word;
    end
  end

  // reference falling-edge capture for half rate
  // RQ10: falling edge too
  always_ff @(negedge CLK) begin
    if (!RST_B) begin
      fall_r <= '0;
    end else begin
      fall_r <= in_word;
    end
  end

  // bring reset into host domain
  sxc_sync #(.W(1)) u_host_rst (
    .clk     (HOST_TRANSMIT_CLOCK),
    .d       (RST_B),
    .q       (host_rst_b),
    .settled ()
  );

  // host clock writes the buffer
  // RQ9: host clock capture
  always_ff @(posedge HOST_TRANSMIT_CLOCK) begin
    mem[wr_bin_r[IDX_W-1:0]] <= in_word;
  end

  // write pointer in host domain
  // RQ19: host clock register
  always_ff @(posedge HOST_TRANSMIT_CLOCK) begin
    if (!host_rst_b) begin
      wr_bin_r  <= PTR_ZERO;
      wr_gray_r <= PTR_ZERO;
    end else begin
      wr_bin_r  <= wr_bin_r + PTR_ONE;
      wr_gray_r <= bin2gray(wr_bin_r + PTR_ONE);
    end
  end

  // gray pointer crossing
  sxc_sync #(.W(PTR_W)) u_wr_sync (
    .clk     (CLK),
    .d       (wr_gray_r),
    .q       (wr_gray_s),
    .settled ()
  );

  // phase reset pin crossing
  sxc_sync #(.W(1)) u_prst_sync (
    .clk     (CLK),
    .d       (PHASE_ALIGN_RESET_N),
    .q       (prst_q),
    .settled (prst_settled)
  );

  // accept a level once stages agree
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      prst_low_r <= 1'b0;
    end else if (prst_settled) begin
      prst_low_r <= !prst_q;
    end
  end

  // count consecutive low edges
  // RQ15: two low edges
  always_ff @(posedge CLK) begin
    if (!RST_B || !prst_low_r) begin
      prst_cnt_r <= CNT_ZERO;
    end else if (prst_cnt_r != PRST_EDGES) begin
      prst_cnt_r <= prst_cnt_r + CNT_ONE;
    end
  end

  assign prst_active = prst_low_r && (prst_cnt_r == PRST_EDGES);
  // RQ16: bypass ignores reset
  // RQ13: half rate only clears faults
  assign recenter    = prst_active && !ref_clk_sel;

  assign wr_bin_s  = gray2bin(wr_gray_s);
  assign fill      = wr_bin_s - rd_bin_r;
  assign buf_fault = !ref_clk_sel && (fill >= FILL_FAULT);

  // read pointer; recenter behind the writer
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      rd_bin_r <= PTR_ZERO;
    // RQ11: recenter buffer
    // RQ14: characters repeat or drop
    end else if (recenter || buf_fault) begin
      rd_bin_r <= wr_bin_s - CENTER;
    // RQ12: fixed phase otherwise
    end else if (!ref_clk_sel && fill != PTR_ZERO) begin
      rd_bin_r <= rd_bin_r + PTR_ONE;
    end
  end

  // pick the source of this cycle's words
  always_comb begin
    lane_a    = rise_r;
    lane_a_ok = 1'b1;
    lane_b_ok = 1'b0;
    if (!ref_clk_sel) begin
      lane_a    = mem[rd_bin_r[IDX_W-1:0]];
      lane_a_ok = (fill != PTR_ZERO) && !recenter && !buf_fault;
    end else if (HALF_RATE_SELECT) begin
      lane_b_ok = 1'b1;
    end
  end

  // encoding and parity check
  // RQ2: type from control code
  // RQ3: raw when bypassed
  // RQ6: ten bit raw
  // RQ8: special select use
  // RQ7: parity check
  assign char_a = encode(lane_a, enc_on, PARITY_CONTROL);
  assign char_b = encode(fall_r, enc_on, PARITY_CONTROL);
  assign perr_a = lane_a_ok && par_bad(lane_a, PARITY_CONTROL);
  assign perr_b = lane_b_ok && par_bad(fall_r, PARITY_CONTROL);
  assign wss_sent = (lane_a_ok && char_a.kind == K_WSS) || (lane_b_ok && char_b.kind == K_WSS);

  // character outputs toward encoder or shifter
  // RQ4: forward characters
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      CHAR_OUT        <= '0;
      CHAR_OUT2       <= '0;
      CHAR_OUT_VALID  <= 1'b0;
      CHAR_OUT2_VALID <= 1'b0;
    end else begin
      CHAR_OUT        <= char_a;
      CHAR_OUT2       <= char_b;
      CHAR_OUT_VALID  <= lane_a_ok;
      CHAR_OUT2_VALID <= lane_b_ok;
    end
  end

  // one-period parity pulse
  // RQ21: pulse on parity fault
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      perr_r <= 1'b0;
    end else begin
      perr_r <= perr_a || perr_b;
    end
  end

  // sticky buffer fault; set wins over clear
  // RQ22: hold until sync or reset
  always_ff @(posedge CLK) begin
    if (!RST_B) begin
      err_hold_r <= 1'b0;
    end else if (buf_fault) begin
      err_hold_r <= 1'b1;
    end else if (wss_sent || prst_active) begin
      err_hold_r <= 1'b0;
    end
  end

  assign TRANSMIT_PARITY_ERROR_OUT = perr_r || err_hold_r;
  assign PHASE_ALIGN_ACTIVE        = recenter;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_B);
  // phase reset seen low on two settled edges
  sequence s_low_twice;
    prst_low_r ##1 prst_low_r;
  endsequence
  property p_perr_viol;
    perr_a |=> (CHAR_OUT.kind == K_VIOL) && TRANSMIT_PARITY_ERROR_OUT;
  endproperty
  a_perr_viol: assert property (p_perr_viol) else $error("no violation on parity fault"); // RQ21
  property p_raw_bypass;
    (lane_a_ok && !enc_on && !perr_a) |=> (CHAR_OUT.kind == K_RAW) &&
      (CHAR_OUT.bits == $past({lane_a.ct, lane_a.chr}));
  endproperty
  a_raw_bypass: assert property (p_raw_bypass) else $error("bypass char not raw"); // RQ6
  property p_ignore_prst;
    (buf_bypass && prst_low_r) |-> !PHASE_ALIGN_ACTIVE ##1 CHAR_OUT_VALID;
  endproperty
  a_ignore_prst: assert property (p_ignore_prst) else $error("reset acted in bypass"); // RQ16
  property p_hold;
    (err_hold_r && !wss_sent && !prst_active) |=> err_hold_r && TRANSMIT_PARITY_ERROR_OUT;
  endproperty
  a_hold: assert property (p_hold) else $error("buffer fault dropped early"); // RQ22
  property p_recenter_cause;
    $rose(recenter) |-> $past(prst_low_r) && $past(prst_low_r, 2);
  endproperty
  a_recenter_cause: assert property (p_recenter_cause) else $error("recenter too soon"); // RQ11
  property p_recenter_start;
    (s_low_twice ##1 (prst_low_r && !ref_clk_sel)) |-> PHASE_ALIGN_ACTIVE;
  endproperty
  a_recenter_start: assert property (p_recenter_start) else $error("recenter missed"); // RQ15
  property p_full_rate;
    buf_bypass |=> CHAR_OUT_VALID && !CHAR_OUT2_VALID &&
      (CHAR_OUT == $past(char_a));
  endproperty
  a_full_rate: assert property (p_full_rate) else $error("full rate path wrong"); // RQ19
  property p_half_rate;
    (ref_clk_sel && HALF_RATE_SELECT) |=> CHAR_OUT2_VALID && CHAR_OUT_VALID;
  endproperty
  a_half_rate: assert property (p_half_rate) else $error("half rate lane missing"); // RQ10
  property p_no_empty_read;
    (!ref_clk_sel && fill == PTR_ZERO) |=> !CHAR_OUT_VALID;
  endproperty
  a_no_empty_read: assert property (p_no_empty_read) else $error("read from empty buffer"); // RQ12
  property p_wss_kind;
    (lane_a_ok && enc_on && !perr_a && lane_a.ct == CT_WSS && lane_a.sc)
      |=> CHAR_OUT.kind == K_WSS;
  endproperty
  a_wss_kind: assert property (p_wss_kind) else $error("sync sequence not chosen"); // RQ8

endmodule

`default_nettype wire

// *** dv/sxc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// host logic launching one word per host clock rising edge
module sxc_host_model
  import sxc_pkg::*;
(
  input  wire logic      run,      // host clock runs only while high
  output logic           HOST_CLK, // host transmit clock, 160 ns period
  output var sxc_word_t  WORD      // word launched after each rising edge
);
  logic [7:0] cnt_r = 8'h00; // running character value

  // clock stands still low between frames, offset phase
  initial begin
    HOST_CLK = 1'b0;
    #3.7;
    forever begin
      #80;
      if (run || HOST_CLK) begin
        HOST_CLK = ~HOST_CLK;
      end
    end
  end

  // word fields launched together
  // released lines: parity pulls up, select pulls down, rest inverted
  always @(posedge HOST_CLK or negedge run) begin
    if (!run) begin
      WORD <= '{chr: ~WORD.chr, ct: ~WORD.ct, par: 1'b1, sc: 1'b0};
    end else begin
      cnt_r <= cnt_r + 8'h01;
      WORD  <= '{chr: cnt_r, ct: CT_DATA, par: ~^cnt_r, sc: cnt_r[0]};
    end
  end
endmodule

`default_nettype wire

// *** dv/testbench.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("[FAIL] %s exp %h got %h", nm, e, g); end end

module testbench
  import sxc_pkg::*;
();
  logic       clk = 1'b0, rst_b, prst_n, half, host_run, htc, bad_on; // bench drives
  logic [1:0] isel, mode, pctl;                               // static config
  logic       perr, cv, cv2, pact;                            // design flags
  sxc_char_t  co, co2;                                        // design characters
  sxc_word_t  bw, hw, in_w;                                   // bench, host, muxed word
  int         error_cnt, check_count, cyc;                    // counters

  // host model feeds the port only when host clock is selected
  assign in_w = (isel == LVL_LOW) ? bw : hw;

  sxc_tx_input_port sxc_tx_input_port_inst (
    .CLK(clk), .RST_B(rst_b), .HOST_TRANSMIT_CLOCK(htc), .TX_CHAR(in_w.chr),
    .TRANSMIT_CHAR_TYPE_CODE(in_w.ct), .TRANSMIT_ODD_PARITY_IN(in_w.par),
    .SPECIAL_CHAR_SELECT(in_w.sc), .PHASE_ALIGN_RESET_N(prst_n), .INPUT_CLOCK_SELECT(isel),
    .HALF_RATE_SELECT(half), .TRANSMIT_CODING_MODE(mode), .PARITY_CONTROL(pctl),
    .TRANSMIT_PARITY_ERROR_OUT(perr), .CHAR_OUT(co), .CHAR_OUT_VALID(cv), .CHAR_OUT2(co2),
    .CHAR_OUT2_VALID(cv2), .PHASE_ALIGN_ACTIVE(pact));

  sxc_host_model sxc_host_model_inst (.run(host_run), .HOST_CLK(htc), .WORD(hw));

  // 50 MHz reference clock
  always #10 clk = ~clk;

  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      error_cnt++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // deliberately bad parity on every fifth word
  function automatic logic bad(input int i);
    return bad_on && (i % 5 == 3);
  endfunction

  // stimulus word with correct odd parity unless flipped
  function automatic sxc_word_t mk(input int i, input logic flip);
    sxc_word_t w;
    w.chr = 8'h3c + 8'(i * 7);
    w.ct  = 2'(i);
    w.sc  = i[2];
    w.par = ~(^w.chr ^ ((pctl == LVL_HIGH) ? ^w.ct : 1'b0)) ^ flip;
    return w;
  endfunction

  // expected character for a word
  function automatic sxc_char_t ex(input sxc_word_t w, input logic flip);
    sxc_char_t c;
    c.bits = {w.ct, w.chr};
    if (flip && pctl != LVL_LOW) begin
      c.kind = K_VIOL;
      c.bits = 10'h0e0;
    end else if (!mode[1]) c.kind = K_RAW;
    else begin
      case (w.ct)
        2'h0: c.kind = w.sc ? K_SPECIAL : K_DATA;
        2'h1: c.kind = K_SPECIAL;
        2'h2: c.kind = K_FILL;
        default: c.kind = w.sc ? K_WSS : K_SPECIAL;
      endcase
    end
    return c;
  endfunction

  // new static config applied under reset
  task automatic setup(input logic [1:0] s, input logic h, input logic [1:0] m,
                       input logic [1:0] p);
    @(negedge clk);
    rst_b = 1'b0;
    isel = s;
    half = h;
    mode = m;
    pctl = p;
    repeat (40) @(negedge clk);
    rst_b = 1'b1;
  endtask

  // back-to-back words, each checked two edges later
  task automatic stream(input int n);
    for (int i = 0; i < n + 2; i++) begin
      @(negedge clk);
      if (i >= 2) begin
        `CHK("char", ex(mk(i - 2, bad(i - 2)), bad(i - 2)), co)
        `CHK("valid", 1'b1, cv)
        `CHK("perr", bad(i - 2), perr)
      end
      if (i < n) bw = mk(i, bad(i));
    end
  endtask

  // phase reset low for twelve edges, reports whether recentering showed
  task automatic prst_pulse(output logic seen);
    seen = 1'b0;
    // held low well past two edges
    prst_n = 1'b0;
    repeat (12) begin
      @(negedge clk);
      seen |= pact;
    end
    prst_n = 1'b1;
  endtask

  // encoder on: every code and select pairing, phase reset ignored
  task automatic t_encode();
    logic seen;
    setup(LVL_LOW, 1'b0, 2'h2, LVL_LOW);
    stream(16);
    prst_pulse(seen);
    `CHK("ignored prst", 1'b0, seen)
  endtask

  // bypass: code bits become raw data bits
  task automatic t_bypass();
    setup(LVL_LOW, 1'b0, 2'h1, LVL_LOW);
    stream(8);
  endtask

  // parity over char, over char plus code, and in bypass
  task automatic t_parity();
    bad_on = 1'b1;
    setup(LVL_LOW, 1'b0, 2'h3, LVL_MID);
    stream(20);
    setup(LVL_LOW, 1'b0, 2'h3, LVL_HIGH);
    stream(20);
    setup(LVL_LOW, 1'b0, 2'h0, LVL_MID);
    stream(10);
    bad_on = 1'b0;
  endtask

  // half rate: rising and falling words leave together
  task automatic t_half();
    logic seen;
    setup(LVL_LOW, 1'b1, 2'h2, LVL_LOW);
    for (int i = 0; i < 6; i++) begin
      // both edges sample here, so change between them
      @(negedge clk);
      #5 bw = mk(2 * i, 1'b0);
      @(posedge clk);
      #2 bw = mk(2 * i + 1, 1'b0);
      @(posedge clk);
      #2;
      `CHK("rise char", ex(mk(2 * i, 1'b0), 1'b0), co)
      `CHK("fall char", ex(mk(2 * i + 1, 1'b0), 1'b0), co2)
      `CHK("fall valid", 1'b1, cv2)
    end
    // half rate phase reset never recenters
    prst_pulse(seen);
    `CHK("half prst", 1'b0, seen)
  endtask

  // host clock capture through the phase-align buffer
  task automatic t_host(input logic [1:0] s);
    logic seen;
    logic perr_seen;
    int   last;
    int   n;
    host_run = 1'b1;
    // host clock never combined with half rate
    setup(s, 1'b0, 2'h2, LVL_MID);
    // recenter after reset with host clock running
    prst_pulse(seen);
    repeat (60) @(negedge clk);
    last = -1;
    n = 0;
    perr_seen = 1'b0;
    repeat (200) begin
      @(negedge clk);
      perr_seen |= perr;
      if (cv === 1'b1) begin
        n++;
        `CHK("host kind", co.bits[0] ? K_SPECIAL : K_DATA, co.kind)
        if (last >= 0) `CHK("host order", 8'(last + 1), co.bits[7:0])
        last = co.bits[7:0];
      end
    end
    `CHK("host words", 1'b1, n >= 20)
    `CHK("host perr", 1'b0, perr_seen)
    prst_pulse(seen);
    `CHK("recenter", 1'b1, seen)
    n = 0;
    repeat (100) begin
      @(negedge clk);
      if (cv === 1'b1) n++;
    end
    `CHK("resume", 1'b1, n > 5)
    host_run = 1'b0;
  endtask

  // main sequence
  initial begin
    rst_b = 1'b0;
    prst_n = 1'b1;
    half = 1'b0;
    host_run = 1'b0;
    bad_on = 1'b0;
    isel = LVL_LOW;
    mode = 2'h2;
    pctl = LVL_LOW;
    bw = '0;
    error_cnt = 0;
    check_count = 0;
    repeat (12) @(negedge clk);
    rst_b = 1'b1;
    t_encode();
    t_bypass();
    t_parity();
    t_half();
    t_host(LVL_MID);
    t_host(LVL_HIGH);
    print_verdict();
  end
endmodule

`default_nettype wire
